/* File: psup_top.v */
// psup_top.v: protection supervisor, fault filtering, load-switch control,
// safe-restart timing and apb register file.
// assumes measurement words arrive on clk; comparator flags are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "psup_regs.vh"

// Behaviour
// - overvoltage level is percent of request
// - overvoltage must persist past filter time
// - current regulation default, trip mode selectable
// - overcurrent trip per offer after blanking
// - die overtemperature trip unless disabled
// - die temperature readable for reporting
// - pin overtemperature only in thermistor trip mode
// - open-ground trip unless disabled
// - supply loss holds load switch open
// - undervoltage 60 percent, never below lockout
// - undervoltage response set by firmware, restart default
// - output short: switch off, restart after 1 s
// - data-pin overvoltage off by default, restart type
// - data-pin overvoltage after blanking time
// - channel-pin overvoltage off by default, restart type
// - channel-pin overvoltage after blanking time
// - channel soft short opens load switch
// - safe restart: open switch, timer, reinitialise
// - protections may be set latched
module psup_top #(
  parameter integer BLANK_CYC   = `PSUP_PIN_BLANK_NS / `PSUP_CLK_NS,
  parameter integer OC_BLK_CYC  = `PSUP_OC_BLANK_NS / `PSUP_CLK_NS,
  parameter integer RESTART_CYC = `PSUP_RESTART_NS / `PSUP_CLK_NS
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [14:0] req_voltage_mv,
  input  wire [14:0] vcc_mv,
  input  wire [13:0] iout_ma,
  input  wire [2:0]  active_offer,
  input  wire [7:0]  die_temp_c,
  input  wire [7:0]  connector_temp_c,
  input  wire [7:0]  adapter_temp_c,
  input  wire        gnd_open_cmp,
  input  wire        supply_lockout_cmp,
  input  wire        supply_absent_cmp,
  input  wire        dp_ov_cmp,
  input  wire        dm_ov_cmp,
  input  wire        cc1_ov_cmp,
  input  wire        cc2_ov_cmp,
  input  wire        channel_soft_short_cmp,
  output reg         load_switch_en,
  output reg         supply_loss_guard,
  output reg         reinit_pulse,
  output reg  [7:0]  die_temp_report
);

  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam integer OVP_CYC = `PSUP_OVP_FILT_NS / `PSUP_CLK_NS; // 3000
  localparam [3:0] ST_RUN     = 4'b0001; // output on
  localparam [3:0] ST_WAIT    = 4'b0010; // restart timer running
  localparam [3:0] ST_RESTART = 4'b0100; // one-cycle reinit
  localparam [3:0] ST_LATCH   = 4'b1000; // held off until reset or lockout

  // --------------------------------------------------------------------------
  // synchronisers for comparator flags
  // --------------------------------------------------------------------------
  wire [7:0] async_in = {channel_soft_short_cmp, cc2_ov_cmp, cc1_ov_cmp,
                         dm_ov_cmp, dp_ov_cmp, supply_absent_cmp,
                         supply_lockout_cmp, gnd_open_cmp};
  reg  [7:0] sync1_r;                    // first stage, read only by stage two
  reg  [7:0] sync2_r;                    // safe to use
  // two flops per comparator before any logic looks at it
  always @(posedge clk) begin
    if (srst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end
  wire gnd_open_s = sync2_r[0];
  wire lockout_s  = sync2_r[1];
  wire absent_s   = sync2_r[2];
  wire dpm_s      = sync2_r[3] | sync2_r[4];
  wire cc_s       = sync2_r[5] | sync2_r[6];
  wire short_s    = sync2_r[7];

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  reg [9:0]  enable_r;                   // per-protection enables; overcurrent and lockout bits unused
  reg [9:0]  latch_r;                    // per-protection latched response
  reg [7:0]  ovp_lo_r;                   // percent below split voltage
  reg [7:0]  ovp_hi_r;                   // percent at or above split
  reg [7:0]  uv_pct_r;                   // zero switches undervoltage off
  reg        uv_latch_r;                 // firmware-chosen response
  reg [7:0]  oti_lvl_r;                  // die trip level, degrees
  reg [7:0]  ote_lvl_r;                  // pin trip level, degrees
  reg [1:0]  pin1_mode_r;                // connector_temp_pin mode
  reg [1:0]  pin2_mode_r;                // adapter_temp_pin mode
  reg [31:0] oc_blank_r;                 // overcurrent blanking, cycles
  reg [14:0] oc_tab_r [0:6];             // per offer: [14] trip mode, level
  reg [9:0]  fault_r;                    // sticky fault causes
  reg [3:0]  state_r;
  reg [31:0] timer_r;                    // restart timer

  // --------------------------------------------------------------------------
  // raw trip conditions
  // --------------------------------------------------------------------------
  wire [7:0]  ovp_pct  = (req_voltage_mv < `PSUP_OVP_SPLIT_MV) ? ovp_lo_r
                                                               : ovp_hi_r;
  wire [23:0] vcc_x100 = {9'h000, vcc_mv} * `PSUP_PCT_SCALE;
  wire [23:0] ovp_lvl  = {9'h000, req_voltage_mv} * {16'h0000, ovp_pct};
  wire [23:0] uv_calc  = {9'h000, req_voltage_mv} * {16'h0000, uv_pct_r};
  wire [23:0] lock_x100 = `PSUP_LOCKOUT_MV * `PSUP_PCT_SCALE;
  // never let the undervoltage level sink under the lockout level
  wire [23:0] uv_lvl   = (uv_calc < lock_x100) ? lock_x100 : uv_calc;
  wire [14:0] oc_ent   = (active_offer < 3'd7) ? oc_tab_r[active_offer]
                                               : 15'h0000;
  // trip mode only for the active offer; else current loop limits
  wire        oc_raw   = oc_ent[14] & ({1'b0, iout_ma} > {1'b0, oc_ent[13:0]});
  wire        ovp_raw  = enable_r[`PSUP_F_OVP] & (vcc_x100 > ovp_lvl);
  wire        uv_raw   = enable_r[`PSUP_F_UV] & (uv_pct_r != 8'h00)
                         & (vcc_x100 < uv_lvl) & state_r[0];
  wire        dpov_raw = enable_r[`PSUP_F_DPOV] & dpm_s;
  wire        ccov_raw = enable_r[`PSUP_F_CCOV] & cc_s;

  // --------------------------------------------------------------------------
  // persistence filters, one per filtered condition
  // --------------------------------------------------------------------------
  wire [3:0]   filt_in  = {ccov_raw, dpov_raw, oc_raw, ovp_raw};
  wire [127:0] filt_lim = {BLANK_CYC[31:0], BLANK_CYC[31:0], oc_blank_r,
                           OVP_CYC[31:0]};
  wire [3:0]   filt_out;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
      reg  [31:0] cnt_r;                 // cycles condition has held
      wire [31:0] lim = filt_lim[gi*32 +: 32];
      // any drop of the condition restarts the count
      always @(posedge clk) begin
        if (srst || !filt_in[gi]) begin
          cnt_r <= 32'h0000_0000;
        end else if (cnt_r != lim) begin
          cnt_r <= cnt_r + 32'h0000_0001;
        end
      end
      // fires only once held beyond the limit
      assign filt_out[gi] = filt_in[gi] & (cnt_r == lim);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // fault vector
  // --------------------------------------------------------------------------
  wire ote_hit = ((pin1_mode_r == `PSUP_PINMODE_TRIP) & (connector_temp_c > ote_lvl_r))
               | ((pin2_mode_r == `PSUP_PINMODE_TRIP) & (adapter_temp_c > ote_lvl_r));
  wire [9:0] fault_now;
  assign fault_now[`PSUP_F_OVP]   = filt_out[0];
  assign fault_now[`PSUP_F_OC]    = filt_out[1];
  assign fault_now[`PSUP_F_OTI]   = enable_r[`PSUP_F_OTI] & (die_temp_c > oti_lvl_r);
  assign fault_now[`PSUP_F_OTE]   = enable_r[`PSUP_F_OTE] & ote_hit;
  assign fault_now[`PSUP_F_GND]   = enable_r[`PSUP_F_GND] & gnd_open_s;
  assign fault_now[`PSUP_F_UV]    = uv_raw;
  assign fault_now[`PSUP_F_DPOV]  = filt_out[2];
  assign fault_now[`PSUP_F_CCOV]  = filt_out[3];
  assign fault_now[`PSUP_F_SHORT] = enable_r[`PSUP_F_SHORT] & short_s;
  assign fault_now[`PSUP_F_LOCK]  = lockout_s;

  // undervoltage takes its response from firmware, lockout never latches
  wire [9:0] latch_sel = {1'b0, latch_r[8:6], uv_latch_r, latch_r[4:0]};
  wire       any_trip  = |fault_now;
  wire       go_latch  = |(fault_now & latch_sel);

  // --------------------------------------------------------------------------
  // supervisor state machine
  // --------------------------------------------------------------------------
  reg [3:0]  state_nxt;
  reg [31:0] timer_nxt;
  always @* begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    case (state_r)
      ST_RUN: begin
        if (any_trip) begin
          state_nxt = go_latch ? ST_LATCH : ST_WAIT;
          timer_nxt = 32'h0000_0000;
        end
      end
      ST_WAIT: begin
        if (lockout_s) begin
          // supply still short: start the restart time over
          timer_nxt = 32'h0000_0000;
        end else if (timer_r == RESTART_CYC - 1) begin
          state_nxt = ST_RESTART;
        end else begin
          timer_nxt = timer_r + 32'h0000_0001;
        end
      end
      ST_RESTART: begin
        state_nxt = ST_RUN;
      end
      ST_LATCH: begin
        // a lockout releases a latched trip into the restart wait
        if (lockout_s) begin
          state_nxt = ST_WAIT;
          timer_nxt = 32'h0000_0000;
        end
      end
      default: begin
        state_nxt = ST_WAIT;
        timer_nxt = 32'h0000_0000;
      end
    endcase
  end

  // state, switch and reinit flops
  always @(posedge clk) begin
    if (srst) begin
      state_r           <= ST_WAIT;
      timer_r           <= 32'h0000_0000;
      load_switch_en    <= 1'b0;
      reinit_pulse      <= 1'b0;
      supply_loss_guard <= 1'b0;
      die_temp_report   <= 8'h00;
    end else begin
      state_r           <= state_nxt;
      timer_r           <= timer_nxt;
      // switch opens the same edge a trip is seen; supply loss forces it off
      load_switch_en    <= (state_nxt == ST_RUN) & ~absent_s;
      reinit_pulse      <= (state_nxt == ST_RESTART);
      supply_loss_guard <= absent_s;
      die_temp_report   <= die_temp_c;
    end
  end

  // --------------------------------------------------------------------------
  // apb slave: one wait state, writes land on the completing edge
  // --------------------------------------------------------------------------
  wire       acc_start = psel & penable & ~pready;
  wire       acc_done  = psel & penable & pready;
  wire       wr_done   = acc_done & pwrite;
  wire       oc_hit    = (paddr >= `PSUP_OFF_OC_BASE) & (paddr <= `PSUP_OFF_OC_LAST)
                         & (paddr[1:0] == 2'b00);
  wire [11:0] oc_off   = paddr - `PSUP_OFF_OC_BASE;
  wire [2:0]  oc_idx   = oc_off[4:2];
  wire [9:0]  fault_clr = (wr_done && paddr == `PSUP_OFF_FAULT) ? pwdata[9:0]
                                                                : 10'h000;
  reg  [31:0] rd_mux;
  reg         rd_err;
  // read mux and unmapped-address detection
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `PSUP_OFF_ENABLE:    rd_mux = {22'h00_0000, enable_r};
      `PSUP_OFF_LATCH:     rd_mux = {22'h00_0000, latch_r};
      `PSUP_OFF_OVP_PCT:   rd_mux = {16'h0000, ovp_hi_r, ovp_lo_r};
      `PSUP_OFF_UV:        rd_mux = {23'h00_0000, uv_latch_r, uv_pct_r};
      `PSUP_OFF_TEMP:      rd_mux = {12'h000, pin2_mode_r, pin1_mode_r,
                                     ote_lvl_r, oti_lvl_r};
      `PSUP_OFF_OC_BLANK:  rd_mux = oc_blank_r;
      `PSUP_OFF_STATUS:    rd_mux = {26'h000_0000, supply_loss_guard,
                                     load_switch_en, state_r};
      `PSUP_OFF_FAULT:     rd_mux = {22'h00_0000, fault_r};
      `PSUP_OFF_DIE_TEMP:  rd_mux = {24'h00_0000, die_temp_report};
      default: begin
        if (oc_hit && oc_idx < 3'd7) begin
          rd_mux = {oc_tab_r[oc_idx][14], 17'h0_0000, oc_tab_r[oc_idx][13:0]};
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // bus handshake and register writes
  integer k;
  always @(posedge clk) begin
    if (srst) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      enable_r    <= `PSUP_ENABLE_RST;  // pin overvoltage off at reset
      latch_r     <= `PSUP_LATCH_RST;
      ovp_lo_r    <= `PSUP_OVP_LO_RST;
      ovp_hi_r    <= `PSUP_OVP_HI_RST;
      uv_pct_r    <= `PSUP_UV_RST;
      uv_latch_r  <= 1'b0;              // safe restart unless changed
      oti_lvl_r   <= `PSUP_OTI_RST;
      ote_lvl_r   <= `PSUP_OTE_RST;
      pin1_mode_r <= `PSUP_PINMODE_RST;
      pin2_mode_r <= `PSUP_PINMODE_RST;
      oc_blank_r  <= OC_BLK_CYC[31:0];
      fault_r     <= 10'h000;
      for (k = 0; k < 7; k = k + 1) begin
        oc_tab_r[k] <= 15'h0000;        // current loop by default
      end
    end else begin
      pready  <= acc_start;
      if (acc_start) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= rd_err;
      end else begin
        pslverr <= 1'b0;
      end
      // new faults win over a clear in the same cycle
      fault_r <= (fault_r & ~fault_clr) | fault_now;
      if (wr_done) begin
        case (paddr)
          `PSUP_OFF_ENABLE:    enable_r <= pwdata[9:0];
          `PSUP_OFF_LATCH:     latch_r  <= pwdata[9:0];
          `PSUP_OFF_OVP_PCT: begin
            ovp_lo_r <= pwdata[7:0];
            ovp_hi_r <= pwdata[15:8];
          end
          `PSUP_OFF_UV: begin
            uv_pct_r   <= pwdata[7:0];
            uv_latch_r <= pwdata[8];
          end
          `PSUP_OFF_TEMP: begin
            oti_lvl_r   <= pwdata[7:0];
            ote_lvl_r   <= pwdata[15:8];
            pin1_mode_r <= pwdata[17:16];
            pin2_mode_r <= pwdata[19:18];
          end
          `PSUP_OFF_OC_BLANK:  oc_blank_r <= pwdata;
          default: begin
            if (oc_hit && oc_idx < 3'd7) begin
              oc_tab_r[oc_idx] <= {pwdata[31], pwdata[13:0]};
            end
          end
        endcase
      end
    end
  end

endmodule // psup_top
`default_nettype wire

/* File: psup_regs.vh */
// psup_regs.vh: register offsets, field defaults and timing figures for the
// protection supervisor.
// assumes a 100 MHz core clock and a 32-bit apb register port.
`ifndef PSUP_REGS_VH
`define PSUP_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PSUP_OFF_ENABLE    12'h000
`define PSUP_OFF_LATCH     12'h004
`define PSUP_OFF_OVP_PCT   12'h008
`define PSUP_OFF_UV        12'h00C
`define PSUP_OFF_TEMP      12'h010
`define PSUP_OFF_OC_BLANK  12'h014
`define PSUP_OFF_STATUS    12'h018
`define PSUP_OFF_FAULT     12'h01C
`define PSUP_OFF_DIE_TEMP  12'h020
`define PSUP_OFF_OC_BASE   12'h040
`define PSUP_OFF_OC_LAST   12'h058

// ----------------------------------------------------------------------------
// fault bit positions
// ----------------------------------------------------------------------------
`define PSUP_F_OVP    0
`define PSUP_F_OC     1
`define PSUP_F_OTI    2
`define PSUP_F_OTE    3
`define PSUP_F_GND    4
`define PSUP_F_UV     5
`define PSUP_F_DPOV   6
`define PSUP_F_CCOV   7
`define PSUP_F_SHORT  8
`define PSUP_F_LOCK   9
`define PSUP_NFAULT   10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PSUP_ENABLE_RST  10'h033F
`define PSUP_LATCH_RST   10'h0010
`define PSUP_OVP_LO_RST  8'h7D
`define PSUP_OVP_HI_RST  8'h78
`define PSUP_UV_RST      8'h3C
`define PSUP_OTI_RST     8'h71
`define PSUP_OTE_RST     8'h5A
`define PSUP_PINMODE_RST 2'h2
`define PSUP_PINMODE_TRIP 2'h2

// ----------------------------------------------------------------------------
// levels and timing
// ----------------------------------------------------------------------------
`define PSUP_OVP_SPLIT_MV 15'h2328
`define PSUP_LOCKOUT_MV   24'h00_0B22
`define PSUP_PCT_SCALE    24'h00_0064
`define PSUP_CLK_NS       10
`define PSUP_OVP_FILT_NS  30000
`define PSUP_PIN_BLANK_NS 127000
`define PSUP_OC_BLANK_NS  20000000
`define PSUP_RESTART_NS   1000000000

`endif

/* File: psup_top_asserts.sv */
// psup_top_asserts.sv: port checker for the protection supervisor
// assumes bind into psup_top, one clock, srst synchronous active high
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// checker
// ----------------------------------------------------------------------
module psup_chk #(
  parameter integer RESTART_CYC = 50
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       supply_lockout_cmp,
  input wire logic       supply_absent_cmp,
  input wire logic       load_switch_en,
  input wire logic       supply_loss_guard,
  input wire logic       reinit_pulse,
  input wire logic [7:0] die_temp_c,
  input wire logic [7:0] die_temp_report
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [31:0] off_cnt_r; // cycles with the switch open
  // cleared by reset too, so the restart wait counts from release
  always @(posedge clk) begin
    if (srst || load_switch_en) begin
      off_cnt_r <= 32'h0000_0000;
    end else begin
      off_cnt_r <= off_cnt_r + 32'h0000_0001;
    end
  end
  property p_rst;
    @(posedge clk) disable iff (1'b0) srst |=> !load_switch_en && !reinit_pulse;
  endproperty
  property p_guard;
    supply_loss_guard |-> !load_switch_en;
  endproperty
  property p_absent;
    supply_absent_cmp [*3] |=> supply_loss_guard;
  endproperty
  property p_short;
    supply_lockout_cmp [*3] |=> !load_switch_en;
  endproperty
  property p_reinit_one;
    reinit_pulse |=> !reinit_pulse;
  endproperty
  property p_reinit_on;
    reinit_pulse && !supply_loss_guard |=> load_switch_en;
  endproperty
  property p_sw_on;
    $rose(load_switch_en) |-> $past(reinit_pulse) || $past(supply_loss_guard);
  endproperty
  property p_wait;
    reinit_pulse |-> off_cnt_r >= RESTART_CYC - 1;
  endproperty
  property p_temp;
    !$past(srst) |-> die_temp_report == $past(die_temp_c);
  endproperty
  a_rst: assert property (p_rst) else $error("switch on after reset");
  a_guard: assert property (p_guard) else $error("switch on at supply loss");
  a_absent: assert property (p_absent) else $error("no supply guard");
  a_short: assert property (p_short) else $error("switch on in lockout");
  a_reinit_one: assert property (p_reinit_one) else $error("long reinit");
  a_reinit_on: assert property (p_reinit_on) else $error("no switch on");
  a_sw_on: assert property (p_sw_on) else $error("switch on early");
  a_wait: assert property (p_wait) else $error("restart too soon");
  a_temp: assert property (p_temp) else $error("temp report wrong");
  c_reinit: cover property (reinit_pulse);
  c_trip: cover property ($fell(load_switch_en));
  c_loss: cover property (supply_loss_guard);
  c_err: cover property (pready && pslverr);
endmodule // psup_chk

bind psup_top psup_chk #(.RESTART_CYC(RESTART_CYC)) u_chk (
  .clk(clk), .srst(srst), .pready(pready), .pslverr(pslverr),
  .supply_lockout_cmp(supply_lockout_cmp), .supply_absent_cmp(supply_absent_cmp),
  .load_switch_en(load_switch_en), .supply_loss_guard(supply_loss_guard),
  .reinit_pulse(reinit_pulse), .die_temp_c(die_temp_c), .die_temp_report(die_temp_report)
);
`default_nettype wire

/* File: psup_front.sv */
// psup_front.sv: output rail model behind the load switch
// assumes the bench sets the healthy rail level and a short request
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// rail model
// ----------------------------------------------------------------------
module psup_front (
  input  wire logic        clk,
  input  wire logic        load_switch_en,
  input  wire logic        short_on,
  input  wire logic [14:0] vset_mv,
  output wire logic [14:0] vcc_mv,
  output var  logic        supply_lockout_cmp
);
  // a short only pulls the rail down while the switch is closed
  assign vcc_mv = (short_on && load_switch_en) ? 15'h0000 : vset_mv;
  initial supply_lockout_cmp = 1'b0;
  // lockout comparator, fixed level
  always @(posedge clk) begin
    supply_lockout_cmp <= (vcc_mv < 15'h0B22);
  end
endmodule // psup_front
`default_nettype wire

/* File: psup_top_tb_top.sv */
// psup_top_tb_top.sv: self-checking bench for the protection supervisor
// assumes psup_regs.vh offsets and short counts set below
`timescale 1ns/1ps
`default_nettype none
`include "psup_regs.vh"
module psup_top_tb_top;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_q;
  logic        pready, pslverr, err_q, sw_en, loss, reinit, lockout;
  logic [14:0] req = 15'h1388, vset = 15'h1388, vcc;
  logic [13:0] iout = 0;
  logic [7:0]  die = 8'h28, conn = 8'h1E, adap = 8'h19, die_rep;
  logic [2:0]  offer = 0;
  logic [4:0]  cmpv = 0; // data pins, channel pins, soft short
  logic        gnd_open = 0, absent = 0, short_on = 0;
  int          fail_count = 0, samples_checked = 0, cyc = 0, k;
  localparam logic [11:0] RA [10] = '{`PSUP_OFF_ENABLE, `PSUP_OFF_LATCH,
    `PSUP_OFF_OVP_PCT, `PSUP_OFF_UV, `PSUP_OFF_TEMP, `PSUP_OFF_OC_BLANK,
    `PSUP_OFF_STATUS, `PSUP_OFF_FAULT, `PSUP_OFF_DIE_TEMP, 12'h030};
  localparam logic [31:0] RV [10] = '{32'h33F, 32'h10, 32'h787D, 32'h3C,
    32'hA_5A71, 32'h1E, 32'h11, 32'h0, 32'h28, 32'h0};
  // rows: request, rail, hold cycles, switch expected afterwards
  localparam logic [14:0] TR [8] = '{5000, 5000, 5000, 5000, 9000, 9000, 5000, 5000};
  localparam logic [14:0] TV [8] = '{6100, 6300, 6300, 6300, 10800, 10801, 3000, 2999};
  localparam int          TH [8] = '{3100, 2990, 2990, 3100, 3100, 3100, 3100, 3100};
  localparam logic        TE [8] = '{1, 1, 1, 0, 1, 0, 1, 0};
  always #5 clk = ~clk;
  psup_front fe (.clk(clk), .load_switch_en(sw_en), .short_on(short_on),
    .vset_mv(vset), .vcc_mv(vcc), .supply_lockout_cmp(lockout));
  psup_top #(.BLANK_CYC(20), .OC_BLK_CYC(30), .RESTART_CYC(50)) dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_voltage_mv(req), .vcc_mv(vcc), .iout_ma(iout),
    .active_offer(offer), .die_temp_c(die), .connector_temp_c(conn),
    .adapter_temp_c(adap), .gnd_open_cmp(gnd_open), .supply_lockout_cmp(lockout),
    .supply_absent_cmp(absent), .dp_ov_cmp(cmpv[0]), .dm_ov_cmp(cmpv[1]),
    .cc1_ov_cmp(cmpv[2]), .cc2_ov_cmp(cmpv[3]), .channel_soft_short_cmp(cmpv[4]),
    .load_switch_en(sw_en), .supply_loss_guard(loss), .reinit_pulse(reinit),
    .die_temp_report(die_rep));
  task finish_test;
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // wait for the answer; only the hang guard ends a lost one
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    check(rd_q, exp);
  endtask
  task hold(input int n, input logic e);
    repeat (n) @(posedge clk);
    check(sw_en, e);
  endtask
  task wait_run;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (sw_en === 1'b1) break;
    end
    check(sw_en, 1);
  endtask
  // back to healthy levels, then wait for the restart to finish
  task nominal;
    vset <= 5000;
    req <= 5000;
    iout <= 0;
    die <= 8'h28;
    conn <= 8'h1E;
    adap <= 8'h19;
    cmpv <= 0;
    absent <= 0;
    gnd_open <= 0;
    short_on <= 0;
    wait_run();
  endtask
  task do_reset;
    srst <= 1;
    repeat (12) @(posedge clk);
    srst <= 0;
    hold(2, 0);
    wait_run();
  endtask
  initial begin
    do_reset();
    for (k = 0; k < 10; k++) rd(RA[k], RV[k]);
    check(err_q, 1);
    for (k = 0; k < 8; k++) begin
      req <= TR[k];
      vset <= TV[k];
      hold(TH[k], TE[k]);
      vset <= 5000;
      req <= 5000;
      if (TE[k]) @(posedge clk);
      else wait_run();
    end
    iout <= 2000;
    hold(40, 1);
    apb(1, `PSUP_OFF_OC_BASE, 32'h8000_03E8);
    iout <= 1000;
    hold(40, 1);
    offer <= 1;
    iout <= 1001;
    hold(40, 1);
    offer <= 0;
    hold(40, 0);
    nominal();
    die <= 113;
    hold(5, 1);
    check(die_rep, 8'h71);
    die <= 114;
    hold(5, 0);
    nominal();
    apb(1, `PSUP_OFF_TEMP, 32'h5_5A71);
    conn <= 100;
    hold(5, 1);
    apb(1, `PSUP_OFF_TEMP, 32'hA_5A71);
    hold(5, 0);
    nominal();
    adap <= 100;
    hold(5, 0);
    nominal();
    cmpv <= 1;
    hold(40, 1);
    apb(1, `PSUP_OFF_ENABLE, 32'h3FF);
    hold(15, 1);
    for (k = 0; k < 5; k++) begin
      cmpv <= 5'h01 << k;
      hold(40, 0);
      nominal();
    end
    absent <= 1;
    hold(5, 0);
    check(loss, 1);
    absent <= 0;
    hold(5, 1);
    short_on <= 1;
    hold(5, 0);
    short_on <= 0;
    hold(30, 0);
    wait_run();
    apb(1, `PSUP_OFF_UV, 32'h0000_013C);
    vset <= 2999;
    hold(10, 0);
    rd(`PSUP_OFF_STATUS, 32'h08);
    vset <= 2800;
    hold(20, 0);
    vset <= 5000;
    hold(45, 0);
    wait_run();
    gnd_open <= 1;
    hold(5, 0);
    gnd_open <= 0;
    hold(100, 0);
    rd(`PSUP_OFF_STATUS, 32'h08);
    do_reset();
    finish_test();
  end
endmodule // psup_top_tb_top
`default_nettype wire
